// *** design/tieoff_override_and_level_readout.v ***
// Tie-off override, bias trim and level readout register bank
`timescale 1ns/1ps
`default_nettype none
`include "tieoff_override_consts.vh"

module tieoff_override_and_level_readout
#(
  parameter DW = 9
)
(
  input  wire          clock_i,
  input  wire          reset_i,
  input  wire          enable_i,
  input  wire          wr_strobe_i,
  input  wire [6:0]    addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o,
  input  wire [7:0]    auto_input_tie_i,
  input  wire          auto_buf_bypass_i,
  input  wire          auto_buf_ground_i,
  input  wire          input_buffer_enabled_i,
  input  wire [2:0]    power_ref_divider_i,
  input  wire [DW-1:0] left_p2p_i,
  input  wire [DW-1:0] right_p2p_i,
  input  wire [DW-1:0] left_peak_i,
  input  wire [DW-1:0] right_peak_i,
  input  wire          left_under_loop_i,
  input  wire          right_under_loop_i,
  input  wire          supply_high_pin_i,
  input  wire          noise_gate_i,
  input  wire          analog_automute_i,
  input  wire          left_digital_mute_i,
  input  wire          right_digital_mute_i,
  output reg  [7:0]    input_tie_switch_o,
  output reg           input_bias_half_o,
  output reg           input_bias_raise_o,
  output reg           input_bias_lower_o,
  output reg           buf_bypass_switch_o,
  output reg           buf_ground_switch_o,
  output reg  [2:0]    ref_divider_switch_o,
  output reg           automute_source_select_o
);

  // ----------------------------------------
  // Local sizes and reset words
  // ----------------------------------------
  localparam          TIE_W    = 8;
  localparam          REF_W    = 3;
  localparam [DW-1:0] TIE_RST  = `RESET_INPUT_TIE;
  localparam [DW-1:0] BIAS_RST = `RESET_BIAS_TRIM;

  // ----------------------------------------
  // Address match, shared by write and read decode
  // ----------------------------------------
  function addr_hit;
    input [6:0] addr_v;
    input [6:0] target_v;
    begin
      addr_hit = (addr_v == target_v);
    end
  endfunction

  // ----------------------------------------
  // Level selection
  // ----------------------------------------
  function [DW-1:0] pick_level;
    input [DW-1:0] left_v;
    input [DW-1:0] right_v;
    input          left_on;
    input          right_on;
    begin
      if (left_on && right_on)
        pick_level = (left_v > right_v) ? left_v : right_v;
      else if (right_on)
        pick_level = right_v;
      else
        pick_level = left_v;
    end
  endfunction

  // ----------------------------------------
  // Supply-high pin synchroniser
  // ----------------------------------------
  reg supply_meta_q;
  reg supply_high_flag_q;

  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      supply_meta_q      <= 1'b0;
      supply_high_flag_q <= 1'b0;
    end
    else if (enable_i)
    begin
      supply_meta_q      <= supply_high_pin_i;
      supply_high_flag_q <= supply_meta_q;
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_any;
  wire wr_tie;
  wire wr_bias;
  wire wr_amute;

  assign wr_any   = enable_i && wr_strobe_i;
  assign wr_tie   = wr_any && addr_hit(addr_i, `ADDR_INPUT_TIE);
  assign wr_bias  = wr_any && addr_hit(addr_i, `ADDR_BIAS_TRIM);
  assign wr_amute = wr_any && addr_hit(addr_i, `ADDR_AUTOMUTE);

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  reg             ovr_enable_q;
  reg             ovr_enable_d;
  reg [TIE_W-1:0] tie_force_q;
  reg [TIE_W-1:0] tie_force_d;
  reg             bias_half_q;
  reg             bias_half_d;
  reg             bias_spare_q;
  reg             bias_spare_d;
  reg             bias_raise_q;
  reg             bias_raise_d;
  reg             bias_lower_q;
  reg             bias_lower_d;
  reg             bypass_force_q;
  reg             bypass_force_d;
  reg             ground_force_q;
  reg             ground_force_d;
  reg [REF_W-1:0] ref_force_q;
  reg [REF_W-1:0] ref_force_d;
  reg             amute_sel_q;
  reg             amute_sel_d;

  always @*
  begin
    ovr_enable_d   = ovr_enable_q;
    tie_force_d    = tie_force_q;
    bias_half_d    = bias_half_q;
    bias_spare_d   = bias_spare_q;
    bias_raise_d   = bias_raise_q;
    bias_lower_d   = bias_lower_q;
    bypass_force_d = bypass_force_q;
    ground_force_d = ground_force_q;
    ref_force_d    = ref_force_q;
    amute_sel_d    = amute_sel_q;
    if (wr_tie)
    begin
      ovr_enable_d = wdata_i[`BIT_OVR_ENABLE];
      tie_force_d  = wdata_i[TIE_W-1:0];
    end
    if (wr_bias)
    begin
      bias_half_d    = wdata_i[`BIT_BIAS_HALF];
      bias_spare_d   = wdata_i[`BIT_BIAS_SPARE];
      bias_raise_d   = wdata_i[`BIT_BIAS_RAISE];
      bias_lower_d   = wdata_i[`BIT_BIAS_LOWER];
      bypass_force_d = wdata_i[`BIT_BUF_BYPASS];
      ground_force_d = wdata_i[`BIT_BUF_GROUND];
      ref_force_d    = {wdata_i[`BIT_REF_HIGH], wdata_i[`BIT_REF_MID], wdata_i[`BIT_REF_LOW]};
    end
    if (wr_amute)
      amute_sel_d = wdata_i[`BIT_AMUTE_SEL];
  end

  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ovr_enable_q   <= TIE_RST[`BIT_OVR_ENABLE];
      tie_force_q    <= TIE_RST[TIE_W-1:0];
      bias_half_q    <= BIAS_RST[`BIT_BIAS_HALF];
      bias_spare_q   <= BIAS_RST[`BIT_BIAS_SPARE];
      bias_raise_q   <= BIAS_RST[`BIT_BIAS_RAISE];
      bias_lower_q   <= BIAS_RST[`BIT_BIAS_LOWER];
      bypass_force_q <= BIAS_RST[`BIT_BUF_BYPASS];
      ground_force_q <= BIAS_RST[`BIT_BUF_GROUND];
      ref_force_q    <= BIAS_RST[REF_W-1:0];
      amute_sel_q    <= `RESET_AUTOMUTE_SEL;
    end
    else if (enable_i)
    begin
      ovr_enable_q   <= ovr_enable_d;
      tie_force_q    <= tie_force_d;
      bias_half_q    <= bias_half_d;
      bias_spare_q   <= bias_spare_d;
      bias_raise_q   <= bias_raise_d;
      bias_lower_q   <= bias_lower_d;
      bypass_force_q <= bypass_force_d;
      ground_force_q <= ground_force_d;
      ref_force_q    <= ref_force_d;
      amute_sel_q    <= amute_sel_d;
    end
  end

  // ----------------------------------------
  // Per-input tie-off switch selection
  // ----------------------------------------
  wire [TIE_W-1:0] tie_switch_d;

  genvar tie_idx;
  generate
    for (tie_idx = 0; tie_idx < TIE_W; tie_idx = tie_idx + 1)
    begin : tie_sel
      assign tie_switch_d[tie_idx] = ovr_enable_q ? tie_force_q[tie_idx]
                                                  : auto_input_tie_i[tie_idx];
    end
  endgenerate

  // ----------------------------------------
  // Reference divider leg switches
  // ----------------------------------------
  wire [REF_W-1:0] ref_switch_d;

  genvar ref_idx;
  generate
    for (ref_idx = 0; ref_idx < REF_W; ref_idx = ref_idx + 1)
    begin : ref_sel
      assign ref_switch_d[ref_idx] = ref_force_q[ref_idx] | power_ref_divider_i[ref_idx];
    end
  endgenerate

  // ----------------------------------------
  // Input buffer switches
  // ----------------------------------------
  wire bypass_switch_d;
  wire ground_switch_d;

  assign bypass_switch_d = (bypass_force_q && !input_buffer_enabled_i)
                           || auto_buf_bypass_i;
  assign ground_switch_d = (ground_force_q && !input_buffer_enabled_i)
                           || auto_buf_ground_i;

  // ----------------------------------------
  // Switch and bias outputs
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      input_tie_switch_o       <= {TIE_W{1'b0}};
      input_bias_half_o        <= 1'b0;
      input_bias_raise_o       <= 1'b0;
      input_bias_lower_o       <= 1'b0;
      buf_bypass_switch_o      <= 1'b0;
      buf_ground_switch_o      <= 1'b0;
      ref_divider_switch_o     <= {REF_W{1'b0}};
      automute_source_select_o <= 1'b0;
    end
    else if (enable_i)
    begin
      input_tie_switch_o       <= tie_switch_d;
      input_bias_half_o        <= bias_half_q;
      input_bias_raise_o       <= bias_raise_q;
      input_bias_lower_o       <= bias_lower_q;
      buf_bypass_switch_o      <= bypass_switch_d;
      buf_ground_switch_o      <= ground_switch_d;
      ref_divider_switch_o     <= ref_switch_d;
      automute_source_select_o <= amute_sel_q;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [DW-1:0] p2p_level;
  wire [DW-1:0] peak_level;
  wire [DW-1:0] status_word;
  reg  [DW-1:0] rdata_d;

  assign p2p_level   = pick_level(left_p2p_i, right_p2p_i,
                                  left_under_loop_i, right_under_loop_i);
  assign peak_level  = pick_level(left_peak_i, right_peak_i,
                                  left_under_loop_i, right_under_loop_i);
  assign status_word = {{(DW-6){1'b0}}, amute_sel_q, supply_high_flag_q,
                        noise_gate_i, analog_automute_i,
                        left_digital_mute_i, right_digital_mute_i};

  always @*
  begin
    rdata_d = {DW{1'b0}};
    if (addr_hit(addr_i, `ADDR_INPUT_TIE))
      rdata_d = {ovr_enable_q, tie_force_q};
    else if (addr_hit(addr_i, `ADDR_BIAS_TRIM))
      rdata_d = {bias_half_q, bias_spare_q, bias_raise_q, bias_lower_q,
                 bypass_force_q, ground_force_q, ref_force_q};
    else if (addr_hit(addr_i, `ADDR_P2P_READOUT))
      rdata_d = p2p_level;
    else if (addr_hit(addr_i, `ADDR_PEAK_READOUT))
      rdata_d = peak_level;
    else if (addr_hit(addr_i, `ADDR_AUTOMUTE))
      rdata_d = status_word;
  end

  always @(posedge clock_i)
  begin
    if (reset_i)
      rdata_o <= {DW{1'b0}};
    else if (enable_i)
      rdata_o <= rdata_d;
  end

endmodule
`default_nettype wire

// *** design/tieoff_override_consts.vh ***
// Constants for the tie-off override and level readout register bank
// Operation
// - Override enable low: manual input tie bits ignored, automatic switching kept.
// - Override enable high: manual input tie bits replace automatic switching.
// - With override, each input tie bit forces its switch open at 0, closed at 1.
// - Half-bias bit set halves both input mix/boost stage bias currents.
// - Bias-raise bit set adds fixed increment to input stage bias.
// - Bias-lower bit set subtracts fixed decrement from input stage bias.
// - Buffer bypass force closes bypass switch while input buffer disabled.
// - Buffer ground force closes ground switch while input buffer disabled.
// - Each reference divider force bit closes its leg; else power setting rules.
// - Peak-to-peak readout returns loop value, larger channel when both controlled.
// - Peak readout returns loop value, larger channel when both controlled.
// - Automute source select: 0 attenuator input, 1 playback data pin.
// - Supply-high flag reads 1 when speaker supply at or above threshold.
// - Noise gate flag reads 1 while signal below gate threshold.
// - Status register also reports analog automute and per-channel digital mute.
`ifndef TIEOFF_OVERRIDE_CONSTS_VH
`define TIEOFF_OVERRIDE_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_INPUT_TIE        7'h4a
`define ADDR_BIAS_TRIM        7'h4b
`define ADDR_P2P_READOUT      7'h4c
`define ADDR_PEAK_READOUT     7'h4d
`define ADDR_AUTOMUTE         7'h4e

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_INPUT_TIE       9'h000
`define RESET_BIAS_TRIM       9'h000
`define RESET_AUTOMUTE_SEL    1'b0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_OVR_ENABLE        8
`define BIT_BIAS_HALF         8
`define BIT_BIAS_SPARE        7
`define BIT_BIAS_RAISE        6
`define BIT_BIAS_LOWER        5
`define BIT_BUF_BYPASS        4
`define BIT_BUF_GROUND        3
`define BIT_REF_HIGH          2
`define BIT_REF_MID           1
`define BIT_REF_LOW           0
`define BIT_AMUTE_SEL         5
`define BIT_SUPPLY_HIGH       4
`define BIT_NOISE_GATE        3
`define BIT_ANALOG_MUTE       2
`define BIT_LEFT_DMUTE        1
`define BIT_RIGHT_DMUTE       0

`endif

// *** testbench/tieoff_override_and_level_readout_bench.sv ***
// Bench for the tie-off override and level readout bank
`timescale 1ns/1ps
`default_nettype none
module tieoff_override_and_level_readout_bench;
  logic       clock_i = 0, reset_i = 1, enable_i = 1, wr_strobe_i = 0;
  logic [6:0] addr_i = 7'h00;
  logic [8:0] wdata_i = 0, left_p2p_i = 0, right_p2p_i = 0, left_peak_i = 0;
  logic [8:0] right_peak_i = 0, rdata_o;
  logic [7:0] auto_input_tie_i = 0, input_tie_switch_o;
  logic [2:0] power_ref_divider_i = 0, ref_divider_switch_o;
  logic       auto_buf_bypass_i = 0, auto_buf_ground_i = 0, input_buffer_enabled_i = 0;
  logic       left_under_loop_i = 0, right_under_loop_i = 0, supply_high_pin_i = 0;
  logic       noise_gate_i = 0, analog_automute_i = 0, left_digital_mute_i = 0;
  logic       right_digital_mute_i = 0, input_bias_half_o, input_bias_raise_o;
  logic       input_bias_lower_o, buf_bypass_switch_o, buf_ground_switch_o;
  logic       automute_source_select_o;
  int         error_cnt = 0, n_checks = 0;
  tieoff_override_and_level_readout tieoff_override_and_level_readout_i (.*);
  always #4 clock_i = ~clock_i;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge clock_i);
    addr_i = a;
    wdata_i = d;
    wr_strobe_i = 1;
    @(negedge clock_i);
    wr_strobe_i = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    @(negedge clock_i);
    addr_i = a;
    @(negedge clock_i);
    chk(rdata_o, exp);
  endtask
  task automatic t_manual;
    rd(7'h4a, 9'h000);
    auto_input_tie_i = 8'h5a;
    wr(7'h4a, 9'h1a5);
    rd(7'h4a, 9'h1a5);
    chk({1'h0, input_tie_switch_o}, 9'h0a5);
    wr(7'h4a, 9'h0ff);
    auto_input_tie_i = 8'h3c;
    rd(7'h4a, 9'h0ff);
    chk({1'h0, input_tie_switch_o}, 9'h03c);
  endtask
  task automatic t_bias;
    power_ref_divider_i = 3'h4;
    wr(7'h4b, 9'h17a);
    rd(7'h4b, 9'h17a);
    chk({1'h0, input_bias_half_o, input_bias_raise_o, input_bias_lower_o,
      buf_bypass_switch_o, buf_ground_switch_o, ref_divider_switch_o}, 9'h0fe);
    wr(7'h4b, 9'h000);
    rd(7'h4b, 9'h000);
    chk({4'h0, buf_bypass_switch_o, buf_ground_switch_o, ref_divider_switch_o}, 9'h004);
  endtask
  task automatic t_levels;
    left_p2p_i = 9'h0aa;
    right_p2p_i = 9'h155;
    left_peak_i = 9'h1f0;
    right_peak_i = 9'h00f;
    left_under_loop_i = 1;
    right_under_loop_i = 1;
    wr(7'h4c, 9'h1ff);
    rd(7'h4c, 9'h155);
    rd(7'h4d, 9'h1f0);
    rd(7'h10, 9'h000);
  endtask
  task automatic t_status;
    {supply_high_pin_i, noise_gate_i, analog_automute_i, right_digital_mute_i} = 4'hf;
    wr(7'h4e, 9'h1ff);
    rd(7'h4e, 9'h03d);
    chk({8'h0, automute_source_select_o}, 9'h001);
  endtask
  task automatic t_misc;
    supply_high_pin_i = 0;
    enable_i = 0;
    wr(7'h4a, 9'h1ff);
    enable_i = 1;
    rd(7'h4a, 9'h0ff);
    auto_buf_bypass_i = 1;
    auto_buf_ground_i = 1;
    right_under_loop_i = 0;
    rd(7'h4c, 9'h0aa);
    chk({7'h0, buf_bypass_switch_o, buf_ground_switch_o}, 9'h003);
    left_under_loop_i = 0;
    right_under_loop_i = 1;
    rd(7'h4d, 9'h00f);
    rd(7'h4e, 9'h02d);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clock_i);
    reset_i = 0;
    t_manual();
    t_bias();
    t_levels();
    t_status();
    t_misc();
    final_report();
  end
  initial
  begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire

// *** testbench/tieoff_override_checker_sva.sv ***
// Assertions for the tie-off override and level readout bank
`timescale 1ns/1ps
`default_nettype none
module tieoff_override_checker #(parameter DW = 9)
(
  input wire logic          clock_i, reset_i, enable_i, wr_strobe_i,
  input wire logic [6:0]    addr_i,
  input wire logic [DW-1:0] wdata_i, rdata_o, left_p2p_i, right_p2p_i,
  input wire logic [7:0]    auto_input_tie_i, input_tie_switch_o,
  input wire logic          auto_buf_bypass_i, input_buffer_enabled_i, auto_buf_ground_i,
  input wire logic          buf_ground_switch_o,
  input wire logic [2:0]    power_ref_divider_i, ref_divider_switch_o,
  input wire logic          left_under_loop_i, right_under_loop_i, noise_gate_i,
  input wire logic          analog_automute_i, left_digital_mute_i, right_digital_mute_i,
  input wire logic          input_bias_half_o, input_bias_raise_o, input_bias_lower_o,
  input wire logic          buf_bypass_switch_o, automute_source_select_o
);
  wire wa = enable_i & wr_strobe_i & (addr_i == 7'h4a);
  wire wb = enable_i & wr_strobe_i & (addr_i == 7'h4b);
  wire we = enable_i & wr_strobe_i & (addr_i == 7'h4e);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_tie_auto: assert property (wa && !wdata_i[8] ##1 enable_i
    |=> input_tie_switch_o == $past(auto_input_tie_i)) else $error("tie not automatic");
  a_tie_manual: assert property (wa && wdata_i[8] ##1 enable_i
    |=> input_tie_switch_o == $past(wdata_i[7:0], 2)) else $error("tie not manual");
  a_bias_trim: assert property (wb ##1 enable_i |=>
    {input_bias_half_o, input_bias_raise_o, input_bias_lower_o} == $past({wdata_i[8],
    wdata_i[6:5]}, 2)) else $error("bias trim wrong");
  a_buf_bypass: assert property (wb ##1 enable_i && !input_buffer_enabled_i |=>
    buf_bypass_switch_o == ($past(wdata_i[4], 2) | $past(auto_buf_bypass_i)))
    else $error("bypass switch wrong");
  a_buf_ground: assert property (wb ##1 enable_i && !input_buffer_enabled_i |=>
    buf_ground_switch_o == ($past(wdata_i[3], 2) | $past(auto_buf_ground_i)))
    else $error("ground switch wrong");
  a_ref_divider: assert property (wb ##1 enable_i |=> ref_divider_switch_o ==
    ($past(wdata_i[2:0], 2) | $past(power_ref_divider_i))) else $error("divider wrong");
  a_amute_select: assert property (we ##1 enable_i
    |=> automute_source_select_o == $past(wdata_i[5], 2)) else $error("select wrong");
  a_p2p_max: assert property (enable_i && addr_i == 7'h4c && left_under_loop_i &&
    right_under_loop_i |=> rdata_o == ($past(left_p2p_i) > $past(right_p2p_i) ?
    $past(left_p2p_i) : $past(right_p2p_i))) else $error("peak-to-peak wrong");
  a_status_bits: assert property (enable_i && addr_i == 7'h4e |=>
    rdata_o[3:0] == $past({noise_gate_i, analog_automute_i, left_digital_mute_i,
    right_digital_mute_i})) else $error("status bits wrong");
endmodule
bind tieoff_override_and_level_readout tieoff_override_checker #(.DW(DW)) chk_i (.*);
`default_nettype wire
